// ===== bench/cte_exec_checker.sv
// Purpose: port assertions for the execution unit
// Assumes: single clock, reset active low
// Notes: memory timing is only bounded where the hand-over fixes it
`default_nettype none
module cte_exec_checker (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CMD_VALID,
  input wire logic CMD_READY,
  input wire cte_pkg::cte_op_t CMD_OP,
  input wire logic CMD_WORD,
  input wire cte_pkg::cte_mode_t CMD_MODE,
  input wire logic [15:0] CMD_DISP,
  input wire logic DONE,
  input wire logic ILLEGAL,
  input wire logic [15:0] RESULT,
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic MEM_WORD,
  input wire logic [15:0] MEM_ADDR,
  input wire logic MEM_ACK
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic tk;
  logic [7:0] disp_lo;
  assign tk = CMD_VALID && CMD_READY;
  assign disp_lo = CMD_DISP[7:0];
  sum_one_cycle_a: assert property (tk && CMD_OP == cte_pkg::OP_SUM |=> DONE)
    else $error("sum not done in one cycle");
  minus_imm_refused_a: assert property (tk && CMD_OP == cte_pkg::OP_MINUS &&
    CMD_MODE != cte_pkg::MODE_REG |=> ILLEGAL && DONE) else $error("minus imm taken");
  word_imm_refused_a: assert property (tk && CMD_WORD && CMD_MODE == cte_pkg::MODE_IMM &&
    CMD_OP inside {cte_pkg::OP_SUM, cte_pkg::OP_COMPARE} |=> ILLEGAL) else $error("word imm");
  refusal_keeps_result_a: assert property (ILLEGAL |-> $stable(RESULT))
    else $error("refusal changed result");
  abs8_page_a: assert property (tk && CMD_MODE == cte_pkg::MODE_ABS8 && !CMD_WORD &&
    CMD_OP inside {cte_pkg::OP_TRANSFER_LOAD, cte_pkg::OP_TRANSFER_STORE}
    |=> MEM_ADDR[15:8] == 8'hff && MEM_ADDR[7:0] == $past(disp_lo)) else $error("abs8 page");
  word_even_a: assert property (MEM_REQ && MEM_WORD |-> !MEM_ADDR[0])
    else $error("odd word address");
  req_held_a: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) &&
    $stable(MEM_WE)) else $error("request dropped early");
  done_after_ack_a: assert property (MEM_REQ && MEM_ACK |=> DONE && !MEM_REQ)
    else $error("no done after ack");
  quotient_time_a: assert property (tk && CMD_OP == cte_pkg::OP_UNSIGNED_QUOTIENT
    |-> ##18 DONE) else $error("quotient late");
  push_word_write_a: assert property (tk && CMD_OP == cte_pkg::OP_PUSH
    |=> MEM_REQ && MEM_WE && MEM_WORD) else $error("push not a word write");
  cover property (tk && CMD_OP == cte_pkg::OP_PUSH);
  cover property (ILLEGAL);
  cover property (MEM_ACK && !MEM_WE);
endmodule
`default_nettype wire

// ===== bench/cte_mem_model.sv
// Purpose: byte-wide memory answering the core bus
// Assumes: one request outstanding, word high byte at the lower address
// Notes: idle read data toggles so a stale value never looks valid
`default_nettype none
module cte_mem_model (
  // bus
  input wire logic clk,
  input wire logic req,
  input wire logic we,
  input wire logic word,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  // answer pacing
  input wire logic [3:0] lat,
  output logic [15:0] rdata,
  output logic ack
);
  logic [7:0] mem [logic [15:0]];
  logic [3:0] cnt = 4'h0;
  initial rdata = 16'h0;
  initial ack = 1'b0;
  always @(posedge clk) begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (req && !ack) begin
      cnt <= cnt + 4'h1;
      if (cnt >= lat) begin
        cnt <= 4'h0;
        ack <= 1'b1;
        if (!we && word) rdata <= {mem[addr], mem[addr + 16'h1]};
        if (!we && !word) rdata <= {8'h0, mem[addr]};
        if (we && word) mem[addr] = wdata[15:8];
        if (we && word) mem[addr + 16'h1] = wdata[7:0];
        if (we && !word) mem[addr] = wdata[7:0];
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Purpose: scenario bench for the transfer and arithmetic unit
// Assumes: memory partner answers after a chosen latency
// Notes: byte registers are reached as {low_half, index}
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, word = 1'b0;
  cte_pkg::cte_op_t op = cte_pkg::OP_SUM;
  cte_pkg::cte_mode_t mode = cte_pkg::MODE_REG;
  logic [3:0] dst = 4'h0, src = 4'h0, lat = 4'h0;
  logic [15:0] imm = 16'h0, disp = 16'h0;
  logic [2:0] vsel = 3'h0;
  logic ready, done, ill, req, we, mword, ack;
  logic [15:0] result, vdata, addr, wdata, rdata;
  logic [7:0] flags;
  int miscompares = 0, n_tests = 0;
  always #25 clk = ~clk;
  cte_exec_unit cte_exec_unit_i (.CLK(clk), .RST_N(rst_n), .CMD_VALID(valid), .CMD_READY(ready),
    .CMD_OP(op), .CMD_WORD(word), .CMD_MODE(mode), .CMD_DST(dst), .CMD_SRC(src), .CMD_IMM(imm),
    .CMD_DISP(disp), .DONE(done), .ILLEGAL(ill), .RESULT(result), .CONDITION_FLAGS_REGISTER(flags),
    .VIEW_SEL(vsel), .VIEW_DATA(vdata), .MEM_REQ(req), .MEM_WE(we), .MEM_WORD(mword),
    .MEM_ADDR(addr), .MEM_WDATA(wdata), .MEM_RDATA(rdata), .MEM_ACK(ack));
  cte_mem_model cte_mem_model_i (.clk(clk), .req(req), .we(we), .word(mword), .addr(addr),
    .wdata(wdata), .lat(lat), .rdata(rdata), .ack(ack));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic run(input cte_pkg::cte_op_t o, input logic w, input cte_pkg::cte_mode_t m,
    input logic [3:0] d, input logic [3:0] s, input logic [15:0] i, input logic [15:0] a = 16'h0);
    int k;
    k = 0;
    @(negedge clk);
    valid = 1'b1;
    op = o;
    word = w;
    mode = m;
    dst = d;
    src = s;
    imm = i;
    disp = a;
    @(negedge clk);
    valid = 1'b0;
    while (done !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    chk("done", {15'h0, done}, 16'h1);
  endtask
  task automatic ld(input logic [2:0] r, input logic [15:0] v);
    run(cte_pkg::OP_TRANSFER_LOAD, 1'b1, cte_pkg::MODE_IMM, {1'b0, r}, 4'h0, v);
  endtask
  task automatic see(input logic [2:0] r, input logic [15:0] exp, input string what);
    vsel = r;
    @(negedge clk);
    chk(what, vdata, exp);
  endtask
  task automatic refuse(input cte_pkg::cte_op_t o, input logic w, input cte_pkg::cte_mode_t m);
    logic [15:0] r;
    r = result;
    run(o, w, m, 4'h2, 4'h2, 16'h3);
    chk("refused", {15'h0, ill}, 16'h1);
    chk("kept result", result, r);
  endtask
  task automatic t_move;
    ld(3'h1, 16'h1234);
    chk("imm load", result, 16'h1234);
    run(cte_pkg::OP_TRANSFER_LOAD, 1'b1, cte_pkg::MODE_REG, 4'h3, 4'h1, 16'h0);
    see(3'h3, 16'h1234, "reg move");
  endtask
  task automatic t_stack;
    lat = 4'h3;
    ld(3'h7, 16'h0100);
    run(cte_pkg::OP_PUSH, 1'b1, cte_pkg::MODE_PRE_DOWN, 4'h1, 4'h1, 16'h0);
    see(3'h7, 16'h00fe, "push pointer");
    run(cte_pkg::OP_POP, 1'b1, cte_pkg::MODE_POST_INC, 4'h4, 4'h4, 16'h0);
    see(3'h4, 16'h1234, "pop data");
    see(3'h7, 16'h0100, "pop pointer");
  endtask
  task automatic t_arith;
    ld(3'h2, 16'h0081);
    run(cte_pkg::OP_SUM, 1'b0, cte_pkg::MODE_IMM, 4'ha, 4'h0, 16'h007f);
    chk("byte sum", result & 16'h00ff, 16'h0000);
    chk("sum flags", {12'h0, flags[3:0]}, 16'h0005);
    run(cte_pkg::OP_CARRY_SUM, 1'b0, cte_pkg::MODE_IMM, 4'ha, 4'h0, 16'h0000);
    chk("carry sum", result & 16'h00ff, 16'h0001);
    refuse(cte_pkg::OP_MINUS, 1'b0, cte_pkg::MODE_IMM);
    refuse(cte_pkg::OP_SUM, 1'b1, cte_pkg::MODE_IMM);
    refuse(cte_pkg::OP_COMPARE, 1'b1, cte_pkg::MODE_IMM);
    refuse(cte_pkg::OP_POINTER_STEP_UP, 1'b1, cte_pkg::MODE_IMM);
    refuse(cte_pkg::OP_TRANSFER_LOAD, 1'b1, cte_pkg::MODE_ABS8);
    run(cte_pkg::OP_STEP_DOWN, 1'b0, cte_pkg::MODE_REG, 4'ha, 4'ha, 16'h0);
    run(cte_pkg::OP_STEP_DOWN, 1'b0, cte_pkg::MODE_REG, 4'ha, 4'ha, 16'h0);
    see(3'h2, 16'h00ff, "step wrap");
    run(cte_pkg::OP_TWOS_COMPLEMENT, 1'b0, cte_pkg::MODE_REG, 4'ha, 4'ha, 16'h0);
    see(3'h2, 16'h0001, "negate");
    run(cte_pkg::OP_SUM, 1'b0, cte_pkg::MODE_IMM, 4'ha, 4'h0, 16'h0009);
    run(cte_pkg::OP_BCD_FIX_AFTER_SUM, 1'b0, cte_pkg::MODE_REG, 4'ha, 4'ha, 16'h0);
    see(3'h2, 16'h0010, "bcd fix");
    run(cte_pkg::OP_COMPARE, 1'b0, cte_pkg::MODE_IMM, 4'ha, 4'h0, 16'h0010);
    chk("compare zero", {15'h0, flags[2]}, 16'h0001);
    see(3'h2, 16'h0010, "compare keeps");
    run(cte_pkg::OP_SUM, 1'b1, cte_pkg::MODE_REG, 4'h2, 4'h1, 16'h0);
    run(cte_pkg::OP_POINTER_STEP_DOWN, 1'b1, cte_pkg::MODE_IMM, 4'h2, 4'h0, 16'h0002);
    see(3'h2, 16'h1242, "word sum step");
    ld(3'h5, 16'h0c0c);
    ld(3'h6, 16'h0d0d);
    run(cte_pkg::OP_UNSIGNED_PRODUCT, 1'b0, cte_pkg::MODE_REG, 4'h5, 4'he, 16'h0);
    see(3'h5, 16'h009c, "product");
    ld(3'h5, 16'h00a8);
    run(cte_pkg::OP_UNSIGNED_QUOTIENT, 1'b0, cte_pkg::MODE_REG, 4'h5, 4'he, 16'h0);
    see(3'h5, 16'h0c0c, "quotient");
  endtask
  task automatic t_mem;
    lat = 4'h0;
    ld(3'h3, 16'h0000);
    run(cte_pkg::OP_TRANSFER_STORE, 1'b0, cte_pkg::MODE_ABS8, 4'h0, 4'h9, 16'h0, 16'h0040);
    chk("abs8 store", {8'h0, cte_mem_model_i.mem[16'hff40]}, 16'h0034);
    run(cte_pkg::OP_TRANSFER_LOAD, 1'b0, cte_pkg::MODE_ABS8, 4'hb, 4'h0, 16'h0, 16'h0040);
    see(3'h3, 16'h0034, "abs8 load");
    ld(3'h4, 16'h2001);
    run(cte_pkg::OP_TRANSFER_STORE, 1'b1, cte_pkg::MODE_INDIRECT, 4'h4, 4'h1, 16'h0);
    chk("odd word", {8'h0, cte_mem_model_i.mem[16'h2000]}, 16'h0012);
    ld(3'h4, 16'h2000);
    run(cte_pkg::OP_TRANSFER_LOAD, 1'b1, cte_pkg::MODE_POST_INC, 4'h3, 4'h4, 16'h0);
    see(3'h3, 16'h1234, "word postinc");
    see(3'h4, 16'h2002, "word step");
    ld(3'h4, 16'h2001);
    run(cte_pkg::OP_TRANSFER_LOAD, 1'b0, cte_pkg::MODE_POST_INC, 4'h3, 4'h4, 16'h0);
    see(3'h4, 16'h2002, "byte step");
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // a run needs well under 2000 cycles; the limit leaves room for slow memory
  initial begin
    #150000;
    miscompares++;
    wrap_up;
  end
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk("reset flags", {8'h0, flags}, 16'h0080);
    t_move;
    t_stack;
    t_arith;
    t_mem;
    wrap_up;
  end
endmodule
bind cte_exec_unit cte_exec_checker cte_exec_checker_i (.CLK(CLK), .RST_N(RST_N),
  .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_OP(CMD_OP), .CMD_WORD(CMD_WORD),
  .CMD_MODE(CMD_MODE), .CMD_DISP(CMD_DISP), .DONE(DONE), .ILLEGAL(ILLEGAL), .RESULT(RESULT),
  .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_WORD(MEM_WORD), .MEM_ADDR(MEM_ADDR),
  .MEM_ACK(MEM_ACK));
`default_nettype wire

// ===== rtl/cte_divider.sv
// Purpose: iterative unsigned divider, one quotient bit per clock
// Assumes: start is a one-cycle pulse while not busy
// Notes: zero divisor yields an all-ones quotient; no trap
`default_nettype none
module cte_divider #(
  parameter int DIVIDEND_W = 16,
  parameter int DIVISOR_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request
  input wire logic start,
  input wire logic [DIVIDEND_W-1:0] dividend,
  input wire logic [DIVISOR_W-1:0] divisor,
  // answer
  output logic busy,
  output logic done,
  output logic [DIVIDEND_W-1:0] quotient,
  output logic [DIVISOR_W-1:0] remainder
);
  localparam int CNT_W = $clog2(DIVIDEND_W + 1);
  localparam logic [CNT_W-1:0] STEPS = CNT_W'(DIVIDEND_W);

  logic [CNT_W-1:0] count;
  logic [DIVISOR_W:0] part;
  logic [DIVISOR_W-1:0] dvs;
  logic [DIVISOR_W:0] shifted;
  logic fits;

  // one extra bit keeps the partial remainder honest before the subtract
  assign shifted = {part[DIVISOR_W-1:0], quotient[DIVIDEND_W-1]};
  assign fits = shifted >= {1'b0, dvs};
  assign remainder = part[DIVISOR_W-1:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      part <= '0;
      dvs <= '0;
      quotient <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        count <= STEPS;
        part <= '0;
        dvs <= divisor;
        quotient <= dividend;
      end else if (busy) begin
        part <= fits ? shifted - {1'b0, dvs} : shifted;
        quotient <= {quotient[DIVIDEND_W-2:0], fits};
        count <= count - CNT_W'(1);
        if (count == CNT_W'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/cte_exec_unit.sv
// Purpose: transfer and arithmetic execution datapath with register file and flags
// Assumes: decoded command in, one instruction at a time, simple memory handshake
// Notes: illegal operand combinations are refused with ILLEGAL and change nothing
`default_nettype none
module cte_exec_unit (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // instruction command
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire cte_pkg::cte_op_t CMD_OP,
  input wire logic CMD_WORD,
  input wire cte_pkg::cte_mode_t CMD_MODE,
  input wire logic [3:0] CMD_DST,
  input wire logic [3:0] CMD_SRC,
  input wire logic [15:0] CMD_IMM,
  input wire logic [15:0] CMD_DISP,
  // completion
  output logic DONE,
  output logic ILLEGAL,
  output logic [15:0] RESULT,
  output logic [7:0] CONDITION_FLAGS_REGISTER,
  // register view
  input wire logic [2:0] VIEW_SEL,
  output logic [15:0] VIEW_DATA,
  // memory bus
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic MEM_WORD,
  output logic [15:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  input wire logic [15:0] MEM_RDATA,
  input wire logic MEM_ACK
);
  typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_DIV} cte_state_t;

  cte_state_t state;
  logic [15:0] gr [8];
  logic [7:0] flags;

  logic [15:0] d_word, s_word, opa, opb;
  logic [7:0] d_byte, s_byte;
  logic imm_mode, reg_or_imm, ill, accept;

  function automatic logic [7:0] byte_of(input logic [15:0] w, input logic lo);
    return lo ? w[7:0] : w[15:8];
  endfunction

  // operand fetch
  always_comb begin
    d_word = gr[CMD_DST[2:0]];
    s_word = gr[CMD_SRC[2:0]];
    d_byte = byte_of(d_word, CMD_DST[3]);
    s_byte = byte_of(s_word, CMD_SRC[3]);
    imm_mode = CMD_MODE == cte_pkg::MODE_IMM;
    reg_or_imm = imm_mode || CMD_MODE == cte_pkg::MODE_REG;
    opa = CMD_WORD ? d_word : {8'h00, d_byte};
    if (imm_mode) begin
      opb = CMD_WORD ? CMD_IMM : {8'h00, CMD_IMM[7:0]};
    end else begin
      opb = CMD_WORD ? s_word : {8'h00, s_byte};
    end
  end

  // operand combinations with no encoding are refused
  always_comb begin
    ill = 1'b0;
    unique case (CMD_OP)
      cte_pkg::OP_TRANSFER_LOAD: begin
        ill = CMD_MODE == cte_pkg::MODE_PRE_DOWN
          || (CMD_MODE == cte_pkg::MODE_ABS8 && CMD_WORD)
          || (CMD_MODE == cte_pkg::MODE_POST_INC && !CMD_WORD
              && CMD_SRC[2:0] == cte_pkg::STACK_POINTER_INDEX);
      end
      cte_pkg::OP_TRANSFER_STORE: begin
        ill = imm_mode || CMD_MODE == cte_pkg::MODE_POST_INC
          || (CMD_MODE == cte_pkg::MODE_ABS8 && CMD_WORD)
          || (CMD_MODE == cte_pkg::MODE_PRE_DOWN && !CMD_WORD
              && CMD_DST[2:0] == cte_pkg::STACK_POINTER_INDEX);
      end
      cte_pkg::OP_PUSH, cte_pkg::OP_POP: ill = 1'b0;
      cte_pkg::OP_SUM: ill = !reg_or_imm || (imm_mode && CMD_WORD);
      cte_pkg::OP_MINUS: ill = CMD_MODE != cte_pkg::MODE_REG;
      cte_pkg::OP_CARRY_SUM, cte_pkg::OP_BORROW_MINUS: begin
        ill = CMD_WORD || !reg_or_imm;
      end
      cte_pkg::OP_STEP_UP, cte_pkg::OP_STEP_DOWN: ill = CMD_WORD;
      cte_pkg::OP_POINTER_STEP_UP, cte_pkg::OP_POINTER_STEP_DOWN: begin
        ill = CMD_IMM != cte_pkg::PTR_STEP_ONE && CMD_IMM != cte_pkg::PTR_STEP_TWO;
      end
      cte_pkg::OP_BCD_FIX_AFTER_SUM, cte_pkg::OP_BCD_FIX_AFTER_MINUS: ill = CMD_WORD;
      cte_pkg::OP_UNSIGNED_PRODUCT, cte_pkg::OP_UNSIGNED_QUOTIENT: ill = 1'b0;
      cte_pkg::OP_COMPARE: ill = !reg_or_imm || (imm_mode && CMD_WORD);
      cte_pkg::OP_TWOS_COMPLEMENT: ill = CMD_WORD;
    endcase
  end

  // adder/subtractor shared by the sum, difference, step, pointer step, compare and negate ops
  logic [15:0] a, b, res;
  logic [16:0] r17;
  logic sub, cin, op_word, carry, vflag, hflag, zero;
  int msb;

  always_comb begin
    a = opa;
    b = opb;
    sub = 1'b0;
    cin = 1'b0;
    op_word = CMD_WORD;
    unique case (CMD_OP)
      cte_pkg::OP_MINUS, cte_pkg::OP_COMPARE: sub = 1'b1;
      cte_pkg::OP_CARRY_SUM: cin = flags[cte_pkg::FLAG_C];
      cte_pkg::OP_BORROW_MINUS: begin
        sub = 1'b1;
        cin = flags[cte_pkg::FLAG_C];
      end
      cte_pkg::OP_STEP_UP: b = cte_pkg::UNIT_STEP;
      cte_pkg::OP_STEP_DOWN: begin
        sub = 1'b1;
        b = cte_pkg::UNIT_STEP;
      end
      cte_pkg::OP_POINTER_STEP_UP, cte_pkg::OP_POINTER_STEP_DOWN: begin
        op_word = 1'b1;
        a = d_word;
        b = CMD_IMM;
        sub = CMD_OP == cte_pkg::OP_POINTER_STEP_DOWN;
      end
      cte_pkg::OP_TWOS_COMPLEMENT: begin
        a = '0;
        b = opa;
        sub = 1'b1;
      end
      default: sub = 1'b0;
    endcase
    if (sub) begin
      r17 = {1'b0, a} - {1'b0, b} - {16'h0000, cin};
    end else begin
      r17 = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
    end
    msb = op_word ? cte_pkg::WORD_MSB : cte_pkg::BYTE_MSB;
    res = op_word ? r17[15:0] : {8'h00, r17[7:0]};
    carry = op_word ? r17[16] : r17[8];
    zero = op_word ? res == '0 : res[7:0] == 8'h00;
    vflag = (sub ? a[msb] != b[msb] : a[msb] == b[msb]) && res[msb] != a[msb];
    hflag = op_word ? (a[cte_pkg::WORD_HALF] ^ b[cte_pkg::WORD_HALF] ^ res[cte_pkg::WORD_HALF])
                    : (a[cte_pkg::BYTE_HALF] ^ b[cte_pkg::BYTE_HALF] ^ res[cte_pkg::BYTE_HALF]);
  end

  // decimal fix works on the byte left by the previous sum or difference
  logic [7:0] bcd_adj, bcd_res;
  logic lo_fix, hi_fix;

  always_comb begin
    if (CMD_OP == cte_pkg::OP_BCD_FIX_AFTER_SUM) begin
      lo_fix = flags[cte_pkg::FLAG_H] || d_byte[3:0] > cte_pkg::BCD_DIGIT_MAX;
      hi_fix = flags[cte_pkg::FLAG_C] || d_byte > cte_pkg::BCD_BYTE_MAX;
    end else begin
      lo_fix = flags[cte_pkg::FLAG_H];
      hi_fix = flags[cte_pkg::FLAG_C];
    end
    bcd_adj = (hi_fix ? cte_pkg::BCD_HI_FIX : 8'h00) | (lo_fix ? cte_pkg::BCD_LO_FIX : 8'h00);
    if (CMD_OP == cte_pkg::OP_BCD_FIX_AFTER_SUM) begin
      bcd_res = d_byte + bcd_adj;
    end else begin
      bcd_res = d_byte - bcd_adj;
    end
  end

  // single-cycle result, register write and flag update
  logic exe_wr, exe_word, exe_fl;
  logic [3:0] exe_idx;
  logic [15:0] exe_val, move_val;
  logic [7:0] exe_flags;

  always_comb begin
    exe_wr = 1'b1;
    exe_word = op_word;
    exe_idx = CMD_DST;
    exe_val = res;
    exe_fl = 1'b1;
    exe_flags = flags;
    move_val = opb;
    exe_flags[cte_pkg::FLAG_N] = res[msb];
    exe_flags[cte_pkg::FLAG_Z] = zero;
    exe_flags[cte_pkg::FLAG_V] = vflag;
    exe_flags[cte_pkg::FLAG_C] = carry;
    exe_flags[cte_pkg::FLAG_H] = hflag;
    unique case (CMD_OP)
      cte_pkg::OP_TRANSFER_LOAD, cte_pkg::OP_TRANSFER_STORE: begin
        if (CMD_OP == cte_pkg::OP_TRANSFER_STORE) begin
          move_val = CMD_WORD ? s_word : {8'h00, s_byte};
        end
        exe_val = move_val;
        exe_word = CMD_WORD;
        exe_flags = flags;
        exe_flags[cte_pkg::FLAG_N] = CMD_WORD ? move_val[15] : move_val[7];
        exe_flags[cte_pkg::FLAG_Z] = CMD_WORD ? move_val == '0 : move_val[7:0] == 8'h00;
        exe_flags[cte_pkg::FLAG_V] = 1'b0;
        exe_wr = CMD_OP == cte_pkg::OP_TRANSFER_LOAD;
      end
      cte_pkg::OP_CARRY_SUM, cte_pkg::OP_BORROW_MINUS: begin
        // zero only survives a chain of zero bytes, for multi-byte tests
        exe_flags[cte_pkg::FLAG_Z] = zero && flags[cte_pkg::FLAG_Z];
      end
      cte_pkg::OP_STEP_UP, cte_pkg::OP_STEP_DOWN: begin
        exe_flags[cte_pkg::FLAG_C] = flags[cte_pkg::FLAG_C];
        exe_flags[cte_pkg::FLAG_H] = flags[cte_pkg::FLAG_H];
      end
      cte_pkg::OP_POINTER_STEP_UP, cte_pkg::OP_POINTER_STEP_DOWN: exe_fl = 1'b0;
      cte_pkg::OP_BCD_FIX_AFTER_SUM, cte_pkg::OP_BCD_FIX_AFTER_MINUS: begin
        exe_val = {8'h00, bcd_res};
        exe_flags[cte_pkg::FLAG_N] = bcd_res[7];
        exe_flags[cte_pkg::FLAG_Z] = bcd_res == 8'h00;
        exe_flags[cte_pkg::FLAG_V] = flags[cte_pkg::FLAG_V];
        exe_flags[cte_pkg::FLAG_C] = hi_fix;
        exe_flags[cte_pkg::FLAG_H] = flags[cte_pkg::FLAG_H];
      end
      cte_pkg::OP_UNSIGNED_PRODUCT: begin
        exe_word = 1'b1;
        exe_val = 16'(d_word[7:0]) * 16'(s_byte);
        exe_fl = 1'b0;
      end
      cte_pkg::OP_COMPARE: exe_wr = 1'b0;
      default: exe_wr = 1'b1;
    endcase
  end

  // effective address and pointer update
  logic is_mem, is_load, eff_word;
  logic [2:0] areg;
  cte_pkg::cte_mode_t eff_mode;
  logic [15:0] base, step, ea, ptr_new;

  always_comb begin
    is_load = CMD_OP == cte_pkg::OP_TRANSFER_LOAD || CMD_OP == cte_pkg::OP_POP;
    eff_word = CMD_WORD;
    eff_mode = CMD_MODE;
    areg = is_load ? CMD_SRC[2:0] : CMD_DST[2:0];
    if (CMD_OP == cte_pkg::OP_PUSH) begin
      eff_word = 1'b1;
      eff_mode = cte_pkg::MODE_PRE_DOWN;
      areg = cte_pkg::STACK_POINTER_INDEX;
    end else if (CMD_OP == cte_pkg::OP_POP) begin
      eff_word = 1'b1;
      eff_mode = cte_pkg::MODE_POST_INC;
      areg = cte_pkg::STACK_POINTER_INDEX;
    end
    is_mem = CMD_OP == cte_pkg::OP_PUSH || CMD_OP == cte_pkg::OP_POP
      || (CMD_OP == cte_pkg::OP_TRANSFER_LOAD && !reg_or_imm)
      || (CMD_OP == cte_pkg::OP_TRANSFER_STORE && CMD_MODE != cte_pkg::MODE_REG);
    base = gr[areg];
    step = eff_word ? cte_pkg::STEP_WORD : cte_pkg::STEP_BYTE;
    unique case (eff_mode)
      cte_pkg::MODE_DISP16: ea = base + CMD_DISP;
      cte_pkg::MODE_PRE_DOWN: ea = base - step;
      cte_pkg::MODE_ABS8: ea = {cte_pkg::ABS8_PAGE, CMD_DISP[7:0]};
      cte_pkg::MODE_ABS16: ea = CMD_DISP;
      default: ea = base;
    endcase
    ea[0] = ea[0] && !eff_word;
    ptr_new = eff_mode == cte_pkg::MODE_POST_INC ? base + step : base - step;
  end

  assign CMD_READY = state == ST_IDLE;
  assign accept = CMD_VALID && state == ST_IDLE;

  // divider for the unsigned quotient op
  logic div_start, div_done;
  logic [15:0] quo;
  logic [7:0] rem;
  logic [2:0] q_dst;
  logic [7:0] q_divisor;

  assign div_start = accept && !ill && CMD_OP == cte_pkg::OP_UNSIGNED_QUOTIENT;

  cte_divider #(
    .DIVIDEND_W(16),
    .DIVISOR_W(8)
  ) u_div (
    .clk(CLK),
    .rst_n(RST_N),
    .start(div_start),
    .dividend(d_word),
    .divisor(s_byte),
    .busy(),
    .done(div_done),
    .quotient(quo),
    .remainder(rem)
  );

  // latched memory access context
  logic m_load, m_word, m_ptr;
  logic [3:0] m_didx;
  logic [2:0] m_areg;
  logic [15:0] m_ptr_new;

  // writeback selection: loaded or computed data wins over a pointer update
  logic wb_en, wb_word, ptr_en;
  logic [3:0] wb_idx;
  logic [15:0] wb_val, ld_val;
  logic [2:0] ptr_idx;
  logic [15:0] ptr_val;

  always_comb begin
    ld_val = m_word ? MEM_RDATA : {8'h00, MEM_RDATA[7:0]};
    wb_en = 1'b0;
    wb_word = exe_word;
    wb_idx = exe_idx;
    wb_val = exe_val;
    ptr_en = 1'b0;
    ptr_idx = m_areg;
    ptr_val = m_ptr_new;
    if (accept && !ill && !is_mem && CMD_OP != cte_pkg::OP_UNSIGNED_QUOTIENT) begin
      wb_en = exe_wr;
    end else if (state == ST_MEM && MEM_ACK) begin
      wb_en = m_load;
      wb_word = m_word;
      wb_idx = m_didx;
      wb_val = ld_val;
      ptr_en = m_ptr;
    end else if (state == ST_DIV && div_done) begin
      wb_en = 1'b1;
      wb_word = 1'b1;
      wb_idx = {1'b0, q_dst};
      wb_val = {rem, quo[7:0]};
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 8; i++) begin
        gr[i] <= '0;
      end
    end else begin
      if (ptr_en) begin
        gr[ptr_idx] <= ptr_val;
      end
      if (wb_en && wb_word) begin
        gr[wb_idx[2:0]] <= wb_val;
      end else if (wb_en && wb_idx[3]) begin
        gr[wb_idx[2:0]][7:0] <= wb_val[7:0];
      end else if (wb_en) begin
        gr[wb_idx[2:0]][15:8] <= wb_val[7:0];
      end
    end
  end

  // sequencing
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      m_load <= 1'b0;
      m_word <= 1'b0;
      m_ptr <= 1'b0;
      m_didx <= '0;
      m_areg <= '0;
      m_ptr_new <= '0;
      q_dst <= '0;
      q_divisor <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (accept && !ill && is_mem) begin
            state <= ST_MEM;
            m_load <= is_load;
            m_word <= eff_word;
            m_didx <= CMD_DST;
            m_areg <= areg;
            m_ptr_new <= ptr_new;
            m_ptr <= eff_mode == cte_pkg::MODE_POST_INC || eff_mode == cte_pkg::MODE_PRE_DOWN;
          end else if (div_start) begin
            state <= ST_DIV;
            q_dst <= CMD_DST[2:0];
            q_divisor <= s_byte;
          end
        end
        ST_MEM: if (MEM_ACK) state <= ST_IDLE;
        ST_DIV: if (div_done) state <= ST_IDLE;
      endcase
    end
  end

  // memory request stands from issue until acknowledged
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      MEM_REQ <= 1'b0;
      MEM_WE <= 1'b0;
      MEM_WORD <= 1'b0;
      MEM_ADDR <= '0;
      MEM_WDATA <= '0;
    end else if (accept && !ill && is_mem) begin
      MEM_REQ <= 1'b1;
      MEM_WE <= !is_load;
      MEM_WORD <= eff_word;
      MEM_ADDR <= ea;
      MEM_WDATA <= eff_word ? s_word : {8'h00, s_byte};
    end else if (MEM_ACK) begin
      MEM_REQ <= 1'b0;
      MEM_WE <= 1'b0;
    end
  end

  // condition flags
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags <= cte_pkg::FLAGS_RESET;
    end else if (accept && !ill && !(is_mem && is_load)) begin
      if (exe_fl && CMD_OP != cte_pkg::OP_UNSIGNED_QUOTIENT
          && CMD_OP != cte_pkg::OP_PUSH) begin
        flags <= exe_flags;
      end
    end else if (state == ST_MEM && MEM_ACK && m_load) begin
      flags[cte_pkg::FLAG_N] <= m_word ? ld_val[15] : ld_val[7];
      flags[cte_pkg::FLAG_Z] <= m_word ? ld_val == '0 : ld_val[7:0] == 8'h00;
      flags[cte_pkg::FLAG_V] <= 1'b0;
    end else if (state == ST_DIV && div_done) begin
      flags[cte_pkg::FLAG_N] <= q_divisor[7];
      flags[cte_pkg::FLAG_Z] <= q_divisor == 8'h00;
    end
  end

  assign CONDITION_FLAGS_REGISTER = flags;

  // completion and observation
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DONE <= 1'b0;
      ILLEGAL <= 1'b0;
      RESULT <= '0;
      VIEW_DATA <= '0;
    end else begin
      VIEW_DATA <= gr[VIEW_SEL];
      DONE <= 1'b0;
      ILLEGAL <= accept && ill;
      if (accept && (ill || !(is_mem || div_start))) begin
        DONE <= 1'b1;
        RESULT <= ill ? RESULT : exe_val;
      end else if (state == ST_MEM && MEM_ACK) begin
        DONE <= 1'b1;
        RESULT <= m_load ? ld_val : MEM_WDATA;
      end else if (state == ST_DIV && div_done) begin
        DONE <= 1'b1;
        RESULT <= {rem, quo[7:0]};
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/cte_pkg.sv
// Purpose: shared types and constants for the transfer/arithmetic execution unit
// Assumes: decoded instructions arrive from the core's decode stage
// Notes: byte register index is {low_half, reg[2:0]}
`default_nettype none
package cte_pkg;

  typedef enum logic [4:0] {
    OP_TRANSFER_LOAD,
    OP_TRANSFER_STORE,
    OP_PUSH,
    OP_POP,
    OP_SUM,
    OP_MINUS,
    OP_CARRY_SUM,
    OP_BORROW_MINUS,
    OP_STEP_UP,
    OP_STEP_DOWN,
    OP_POINTER_STEP_UP,
    OP_POINTER_STEP_DOWN,
    OP_BCD_FIX_AFTER_SUM,
    OP_BCD_FIX_AFTER_MINUS,
    OP_UNSIGNED_PRODUCT,
    OP_UNSIGNED_QUOTIENT,
    OP_COMPARE,
    OP_TWOS_COMPLEMENT
  } cte_op_t;

  typedef enum logic [2:0] {
    MODE_REG,
    MODE_INDIRECT,
    MODE_DISP16,
    MODE_POST_INC,
    MODE_PRE_DOWN,
    MODE_ABS8,
    MODE_ABS16,
    MODE_IMM
  } cte_mode_t;

  localparam logic [2:0] STACK_POINTER_INDEX = 3'h7;
  localparam logic [7:0] ABS8_PAGE = 8'hff;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] PTR_STEP_ONE = 16'h0001;
  localparam logic [15:0] PTR_STEP_TWO = 16'h0002;
  localparam logic [15:0] UNIT_STEP = 16'h0001;

  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_H = 5;
  localparam logic [7:0] FLAGS_RESET = 8'h80;

  localparam int BYTE_MSB = 7;
  localparam int WORD_MSB = 15;
  localparam int BYTE_HALF = 4;
  localparam int WORD_HALF = 12;

  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
  localparam logic [7:0] BCD_LO_FIX = 8'h06;
  localparam logic [7:0] BCD_HI_FIX = 8'h60;

endpackage
`default_nettype wire
